// ===== pcm_pkg.sv
// Package with constants and carrier types for the parallel receiver
package pcm_pkg;
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned STB_MIN_NS   = 500;
    localparam int unsigned ACK_SHORT_NS = 1000;
    localparam int unsigned ACK_LONG_NS  = 3000;
    localparam int unsigned INIT_MIN_NS  = 50_000;
    localparam int unsigned CLK_NS       = 1_000_000_000 / CLK_HZ;
    // Least times round up
    localparam int unsigned STB_CYC      = (STB_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned INIT_CYC     = (INIT_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ACK_SHORT_CYC = ACK_SHORT_NS / CLK_NS;
    localparam int unsigned ACK_LONG_CYC  = ACK_LONG_NS / CLK_NS;
    localparam int unsigned DATA_W       = 8;

    typedef struct packed {
        logic busy;
        logic ack_n;
        logic paper_empty;
        logic selected_flag;
        logic error_n;
    } host_status_t;

    typedef struct packed {
        logic paper_out;
        logic other_fault;
    } fault_t;
endpackage

// ===== pcm_sync.sv
// Two-flop synchroniser with reset value parameter
`timescale 1ns/1ps
module pcm_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk,   // System clock
    input  wire logic rst_n, // Async reset, active low
    input  wire logic d,     // Asynchronous level
    output logic      q      // Synchronised level
);
    logic meta_q;

    // First flop feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ===== parallel_compat_mode_receiver.sv
// Compatibility-mode parallel receiver, device side
`timescale 1ns/1ps
module parallel_compat_mode_receiver
    import pcm_pkg::*;
#(
    parameter int unsigned ACK_CYC_SHORT = ACK_SHORT_CYC,
    parameter int unsigned ACK_CYC_LONG  = ACK_LONG_CYC,
    parameter int unsigned INIT_CYCLES   = INIT_CYC
) (
    input  wire logic              clk,           // 40 MHz system clock
    input  wire logic              rst_n,         // Async reset, active low
    input  wire logic              strobe_n,      // Host strobe, active low
    input  wire logic [DATA_W-1:0] data_in,       // Host data lines
    input  wire logic              init_n,        // Host initialise, active low
    input  wire logic              auto_feed_n,   // Unused host input
    input  wire logic              select_in_n,   // Unused host input
    input  wire fault_t            fault_in,      // Device fault levels
    input  wire logic              ack_long_sel,  // 1 selects long acknowledge
    input  wire logic              rx_ready,      // Consumer can take a byte
    output logic [DATA_W-1:0]      rx_data,       // Received byte
    output logic                   rx_valid,      // One-cycle byte pulse
    output logic                   init_pulse,    // One-cycle reinitialise pulse
    output host_status_t           host_status    // Status lines to host
);
    localparam int unsigned CW = $clog2(INIT_CYCLES + 1);

    // Parameter sanity
    initial begin
        if (ACK_CYC_SHORT < 1 || ACK_CYC_LONG < ACK_CYC_SHORT || INIT_CYCLES < 1)
            $error("Bad parallel receiver timing parameters");
        // Acknowledge counter shares the initialise counter width
        if (ACK_CYC_LONG > INIT_CYCLES)
            $error("Acknowledge width exceeds counter range");
    end

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOW  = 4'h2,
        ST_HAND = 4'h4,
        ST_ACK  = 4'h8
    } state_t;

    state_t            state_q, state_d;
    logic              stb_s, init_s, stb_s_q;
    logic [CW-1:0]     init_cnt_q;
    logic [CW-1:0]     ack_cnt_q;
    logic [DATA_W-1:0] data_q;
    logic              init_done_q;
    logic              err_q;

    wire  unused_ok = auto_feed_n & select_in_n; // Ignored inputs

    // Synchronise strobe and initialise
    pcm_sync #(.RST_VAL(1'b1)) u_sync_stb (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (strobe_n),
        .q     (stb_s)
    );
    pcm_sync #(.RST_VAL(1'b1)) u_sync_init (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (init_n),
        .q     (init_s)
    );

    // Decode of events
    wire stb_fall   = stb_s_q & ~stb_s;
    wire init_hit   = ~init_s && (init_cnt_q == CW'(INIT_CYCLES - 1));
    wire any_fault  = fault_in.paper_out | fault_in.other_fault;
    wire [CW-1:0] ack_len = ack_long_sel ? CW'(ACK_CYC_LONG) : CW'(ACK_CYC_SHORT);
    wire ack_done   = (ack_cnt_q == ack_len - CW'(1));

    // Handshake sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (stb_fall && !err_q)
                    state_d = ST_LOW;
            end
            ST_LOW: begin
                if (stb_s)
                    state_d = ST_HAND;
            end
            ST_HAND: begin
                if (rx_ready && !err_q)
                    state_d = ST_ACK;
            end
            ST_ACK: begin
                if (ack_done)
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // State and strobe history; initialise forces idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            stb_s_q <= 1'b1;
        end else begin
            state_q <= init_hit ? ST_IDLE : state_d;
            stb_s_q <= stb_s;
        end
    end

    // Latch byte on strobe fall; bits kept in order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            data_q <= '0;
        else if (state_q == ST_IDLE && stb_fall && !err_q)
            data_q <= data_in;
    end

    // Acknowledge width counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            ack_cnt_q <= '0;
        else if (state_q == ST_ACK)
            ack_cnt_q <= ack_cnt_q + CW'(1);
        else
            ack_cnt_q <= '0;
    end

    // Initialise low-time counter; fires once per low pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_cnt_q  <= '0;
            init_done_q <= 1'b0;
        end else if (init_s) begin
            init_cnt_q  <= '0;
            init_done_q <= 1'b0;
        end else if (!init_done_q) begin
            init_cnt_q  <= init_cnt_q + CW'(1);
            init_done_q <= init_hit;
        end
    end

    // Fault level registered for the strobe gate; not latched, follows inputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            err_q <= 1'b0;
        else
            err_q <= any_fault;
    end

    // Registered outputs toward host and consumer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_status <= '{busy: 1'b0, ack_n: 1'b1, paper_empty: 1'b0,
                             selected_flag: 1'b1, error_n: 1'b1};
            rx_data     <= '0;
            rx_valid    <= 1'b0;
            init_pulse  <= 1'b0;
        end else begin
            // Busy during entry or error
            host_status.busy <= (state_d != ST_IDLE) | any_fault | ~unused_ok & 1'b0;
            host_status.ack_n <= ~(state_d == ST_ACK) | init_hit;
            host_status.paper_empty <= fault_in.paper_out;
            host_status.selected_flag <= 1'b1;
            host_status.error_n <= ~any_fault;
            rx_valid   <= (state_q == ST_HAND) && rx_ready && !err_q && !init_hit;
            rx_data    <= data_q;
            init_pulse <= init_hit;
        end
    end

    // Checks; the sequences need acknowledge widths of at least 2 and 4 cycles
    sequence s_ack_low;
        !host_status.ack_n [*2];
    endsequence

    sequence s_ack_low_long;
        !host_status.ack_n [*4];
    endsequence

    AST_BUSY_ON_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
        any_fault |=> host_status.busy)
        else $error("busy low during fault");

    AST_ERR_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
        any_fault |=> !host_status.error_n)
        else $error("error line not low in fault");

    AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        !any_fault |=> host_status.error_n)
        else $error("error line low without fault");

    AST_PE_WITH_ERR: assert property (@(posedge clk) disable iff (!rst_n)
        host_status.paper_empty |-> !host_status.error_n)
        else $error("paper empty without error");

    AST_PE_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
        fault_in.paper_out |=> host_status.paper_empty)
        else $error("paper out not reported");

    AST_SELECT_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        host_status.selected_flag)
        else $error("selected flag dropped");

    AST_STB_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_IDLE && stb_fall && !err_q && !init_hit) |=> state_q == ST_LOW)
        else $error("strobe fall not taken");

    // A strobe seen during a fault must leave the machine idle
    AST_REFUSE_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_IDLE && stb_fall && err_q) |=> state_q == ST_IDLE)
        else $error("strobe taken during fault");

    AST_BUSY_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q != ST_IDLE) |-> host_status.busy)
        else $error("busy low during byte entry");

    AST_ACK_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(host_status.ack_n) && !ack_long_sel |-> s_ack_low)
        else $error("acknowledge pulse too short");

    AST_ACK_LONG: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(host_status.ack_n) && ack_long_sel |-> s_ack_low_long)
        else $error("long acknowledge pulse too short");

    // Counter must never run past the chosen width
    AST_ACK_END: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_ACK) |-> ack_cnt_q < ack_len)
        else $error("acknowledge overran its width");

    AST_ACK_WITH_VALID: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(host_status.ack_n) |-> rx_valid)
        else $error("acknowledge without byte");

    AST_BUSY_WITH_ACK: assert property (@(posedge clk) disable iff (!rst_n)
        !host_status.ack_n |-> host_status.busy)
        else $error("busy low during acknowledge");

    AST_BUSY_LOW_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        (state_d == ST_IDLE && !any_fault) |=> !host_status.busy)
        else $error("busy high while able to accept");

    AST_VALID_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        rx_valid |=> !rx_valid)
        else $error("byte pulse longer than one cycle");

    AST_INIT_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
        init_hit |=> init_pulse ##1 !init_pulse)
        else $error("initialise pulse wrong");

    AST_INIT_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        init_hit |=> state_q == ST_IDLE)
        else $error("initialise did not return to idle");

    // Held byte must not change in the cycle before it is delivered
    AST_DATA_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
        rx_valid |-> rx_data == data_q)
        else $error("received byte mismatch");
endmodule

// ===== pcm_host.sv
// Behavioural host port controller for the byte handshake
`timescale 1ns/1ps
module pcm_host
    import pcm_pkg::*;
(
    input  wire logic         clk,         // System clock
    input  wire logic         busy,        // Device busy level
    input  wire logic         ack_n,       // Device acknowledge, active low
    output logic              strobe_n,    // Host strobe, active low
    output logic [DATA_W-1:0] data_in,     // Host data lines
    output logic              init_n,      // Host initialise, active low
    output logic              auto_feed_n, // Toggled, device ignores it
    output logic              select_in_n  // Toggled, device ignores it
);
    // Idle levels: active-low controls released high
    initial begin
        strobe_n = 1'b1;
        init_n = 1'b1;
        data_in = 8'h00;
        auto_feed_n = 1'b1;
        select_in_n = 1'b1;
    end

    // Bounded wait for a level; ok drops on timeout so nothing hangs
    task automatic wait_lvl(input bit on_busy, input logic lvl, inout bit ok);
        int n;
        n = 0;
        while (ok && ((on_busy ? busy : ack_n) !== lvl)) begin
            @(posedge clk);
            #2;
            n++;
            if (n > 400) ok = 1'b0;
        end
    endtask

    // One byte; hs low means no handshake, used for a refused strobe
    task automatic send(input logic [DATA_W-1:0] b, input bit hs, output bit ok);
        ok = 1'b1;
        if (hs) wait_lvl(1'b1, 1'b0, ok);
        data_in = b;
        auto_feed_n = ~auto_feed_n;
        select_in_n = ~select_in_n;
        repeat (STB_CYC) @(posedge clk);
        #2 strobe_n = 1'b0;
        repeat (STB_CYC) @(posedge clk);
        #2 strobe_n = 1'b1;
        if (hs) wait_lvl(1'b0, 1'b0, ok);
        else repeat (STB_CYC) @(posedge clk);
        #2 data_in = ~b; // Released lines float, show the inverse
        if (hs) wait_lvl(1'b0, 1'b1, ok);
    endtask

    // Initialise pulse of a given length in cycles
    task automatic pulse_init(input int cyc);
        init_n = 1'b0;
        repeat (cyc) @(posedge clk);
        #2 init_n = 1'b1;
    endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the parallel receiver
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch at %0t got %0h exp %0h", $time, (a), (b)); end end
module testbench
    import pcm_pkg::*;
;
    localparam int ACK_S = 2;
    localparam int ACK_L = 4;
    logic clk, rst_n, strobe_n, init_n, afd_n, sin_n, ack_long_sel, rx_ready;
    logic rx_valid, init_pulse, ok;
    logic [DATA_W-1:0] data_in, rx_data, b;
    fault_t       fault_in;
    host_status_t host_status;
    logic [DATA_W:0] exp_q[$];
    logic [DATA_W:0] e;
    int fail_count, tests_run, n, i, init_seen;

    parallel_compat_mode_receiver #(.ACK_CYC_SHORT(ACK_S), .ACK_CYC_LONG(ACK_L),
        .INIT_CYCLES(10)) u_parallel_compat_mode_receiver (.clk(clk), .rst_n(rst_n),
        .strobe_n(strobe_n), .data_in(data_in), .init_n(init_n), .auto_feed_n(afd_n),
        .select_in_n(sin_n), .fault_in(fault_in), .ack_long_sel(ack_long_sel),
        .rx_ready(rx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .init_pulse(init_pulse), .host_status(host_status));
    pcm_host u_pcm_host (.clk(clk), .busy(host_status.busy), .ack_n(host_status.ack_n),
        .strobe_n(strobe_n), .data_in(data_in), .init_n(init_n),
        .auto_feed_n(afd_n), .select_in_n(sin_n));

    always #12.5 clk = ~clk;
    // Random consumer stalls keep busy up and delay the acknowledge
    always @(posedge clk) rx_ready <= #2 ($urandom % 4 != 0);
    always @(negedge clk) if (init_pulse === 1'b1) init_seen++;

    // Byte monitor: oldest note against each delivered byte and its ack width
    always @(negedge clk) begin
        if (rx_valid === 1'b1) begin
            `CHK(exp_q.size() != 0, 1'b1)
            e = (exp_q.size() != 0) ? exp_q.pop_front() : '0;
            `CHK(rx_data, e[DATA_W-1:0])
            `CHK(host_status.busy, 1'b1)
            `CHK(host_status.selected_flag, 1'b1)
            n = 0;
            while (host_status.ack_n === 1'b0 && n < 200) begin
                n++;
                @(negedge clk);
            end
            `CHK(n, e[DATA_W] ? ACK_L : ACK_S)
            `CHK(host_status.busy, 1'b0)
        end
    end

    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h9E24));
        clk = 1'b0;
        rst_n = 1'b0;
        fault_in = '0;
        ack_long_sel = 1'b0;
        repeat (6) @(posedge clk);
        #2 rst_n = 1'b1;
        @(posedge clk);
        #2;
        `CHK(host_status, 5'h0B)
        // Bytes with boundary values first, both acknowledge widths
        for (i = 0; i < 14; i++) begin
            b = (i < 2) ? {DATA_W{i[0]}} : DATA_W'($urandom);
            ack_long_sel = (i < 2) ? i[0] : 1'($urandom);
            exp_q.push_back({ack_long_sel, b});
            u_pcm_host.send(b, 1'b1, ok);
            `CHK(ok, 1'b1)
            if (!ok) give_verdict();
        end
        // Every fault combination drives error, paper-empty and busy
        for (i = 0; i < 4; i++) begin
            fault_in = fault_t'(i[1:0]);
            repeat (4) @(posedge clk);
            #2;
            `CHK(host_status.error_n, 1'(i == 0))
            `CHK(host_status.paper_empty, i[1])
            `CHK(host_status.busy, 1'(i != 0))
        end
        // Strobe during a fault is refused; monitor flags any byte
        fault_in = 2'b01;
        u_pcm_host.send(8'hA5, 1'b0, ok);
        fault_in = '0;
        // Short initialise ignored, long one gives a single pulse
        u_pcm_host.pulse_init(5);
        repeat (8) @(posedge clk);
        `CHK(init_seen, 0)
        u_pcm_host.pulse_init(14);
        repeat (8) @(posedge clk);
        #2;
        `CHK(init_seen, 1)
        exp_q.push_back({ack_long_sel, 8'h3C});
        u_pcm_host.send(8'h3C, 1'b1, ok);
        `CHK(ok, 1'b1)
        repeat (10) @(posedge clk);
        `CHK(exp_q.size(), 0)
        give_verdict();
    end
endmodule
